// ---- hdl/paf_pkg.sv ----
// Package: constants for the port alternate-function override block
package paf_pkg;
    // Pin indices within each port
    localparam int PB_SS = 7;
    localparam int PB_SCK = 5;
    localparam int PB_MISO = 4;
    localparam int PB_MOSI = 3;
    localparam int PB_TCLK = 2;
    localparam int PB_T3OUT = 1;
    localparam int PB_T3CAP = 0;
    localparam int PC_ECIN = 0;
    localparam int PC_DIVIDED_CLOCK_OUT = 1;
    localparam int PD_SERIAL_DATA_IN_PIN = 7;
    localparam int PD_TIMER2_MODULATOR_OUT2 = 6;
    localparam int PD_TIMER2_MODULATOR_OUT1 = 5;
    // Widths
    localparam int PB_W = 8;
    localparam int PC_W = 3;
    localparam int PD_W = 3;
    localparam int PD_LO = 5;
    localparam int T2M_W = 4;
    localparam int CMM_W = 2;
    // Encodings
    localparam logic [T2M_W-1:0] T2M_SSI_SPI = 4'h9;
    localparam logic [CMM_W-1:0] CMM_EXT = 2'h3;
    // Reset values
    localparam logic [PB_W-1:0] PB_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 3'h0;
    localparam logic [PD_W-1:0] PD_RST = 3'h0;
    // Peripheral input flops; slave-select idles high so reset never selects
    localparam logic [7:0] PER_RST = 8'h10;
endpackage

// ---- hdl/paf_pin.sv ----
// Generic per-pin override cell: pull-up, direction, value, input enable
`timescale 1ns/10ps
module paf_pin (
    // Register bits
    input wire logic i_dir,
    input wire logic i_data,
    input wire logic i_pud,
    input wire logic i_sleep,
    // Override controls
    input wire logic i_pullup_override_enable,
    input wire logic i_pullup_override_value,
    input wire logic i_ddoe,
    input wire logic i_ddov,
    input wire logic i_port_value_override_enable,
    input wire logic i_port_value_override_value,
    input wire logic i_input_enable_override_enable,
    // Resolved pad controls
    output logic o_oe,
    output logic o_out,
    output logic o_pullup,
    output logic o_in_en
);
    // Override selection, combinational only
    always_comb begin
        o_oe = i_ddoe ? i_ddov : i_dir;
        o_out = i_port_value_override_enable ? i_port_value_override_value : i_data;
        o_pullup = i_pullup_override_enable ? i_pullup_override_value : (!o_oe && i_data && !i_pud);
        // Input forced on when pin change is armed, else off only in sleep
        o_in_en = i_input_enable_override_enable ? 1'b1 : !i_sleep;
    end
endmodule

// ---- hdl/paf_top.sv ----
// Top: alternate-function override for port B, port C and upper port D
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
module paf_top
    import paf_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Global control
    input wire logic i_global_pullup_disable,
    input wire logic i_sleep,
    input wire logic i_clock_output_fuse,
    input wire logic i_divided_clock_out,
    // Port register bits
    input wire logic [PB_W-1:0] i_portb_data,
    input wire logic [PB_W-1:0] i_portb_dir,
    input wire logic [PC_W-1:0] i_portc_data,
    input wire logic [PC_W-1:0] i_portc_dir,
    input wire logic [PD_W-1:0] i_portd_data,
    input wire logic [PD_W-1:0] i_portd_dir,
    // Pad inputs
    input wire logic [PB_W-1:0] i_portb_pad,
    input wire logic [PC_W-1:0] i_portc_pad,
    input wire logic [PD_W-1:0] i_portd_pad,
    // Pin-change enables
    input wire logic [PB_W-1:0] i_pcmask_b,
    input wire logic [PC_W-1:0] i_pcmask_c,
    input wire logic [PD_W-1:0] i_pcmask_d,
    input wire logic i_pin_change_group_b_enable,
    input wire logic i_pin_change_group_c_enable,
    input wire logic i_pin_change_group_d_enable,
    // SPI
    input wire logic i_spi_enable_bit,
    input wire logic i_spi_master_select,
    input wire logic i_spi_sck_out,
    input wire logic i_spi_master_tx,
    input wire logic i_spi_slave_tx,
    // Timers and clock module
    input wire logic i_timer3_out_en,
    input wire logic i_timer3_modulator_out,
    input wire logic [T2M_W-1:0] i_timer2_mode_field,
    input wire logic i_timer2_out1_en,
    input wire logic i_timer2_modulator_out1,
    input wire logic i_timer2_out2_en,
    input wire logic i_timer2_modulator_out2,
    input wire logic [CMM_W-1:0] i_clock_module_mode,
    input wire logic i_external_clock_pin_select,
    input wire logic i_clock_source_select,
    // Pad drive
    output logic [PB_W-1:0] o_portb_oe,
    output logic [PB_W-1:0] o_portb_out,
    output logic [PB_W-1:0] o_portb_pullup,
    output logic [PB_W-1:0] o_portb_in_en,
    output logic [PC_W-1:0] o_portc_oe,
    output logic [PC_W-1:0] o_portc_out,
    output logic [PC_W-1:0] o_portc_pullup,
    output logic [PC_W-1:0] o_portc_in_en,
    output logic [PD_W-1:0] o_portd_oe,
    output logic [PD_W-1:0] o_portd_out,
    output logic [PD_W-1:0] o_portd_pullup,
    output logic [PD_W-1:0] o_portd_in_en,
    // Readback masking
    output logic o_portc_bit0_data_reads_zero,
    // Peripheral inputs
    output logic [PB_W-1:0] o_pin_change_source_b,
    output logic [PC_W-1:0] o_pin_change_source_c,
    output logic [PD_W-1:0] o_pin_change_source_d,
    output logic o_timer_ext_clock_in_b,
    output logic o_timer3_capture_in,
    output logic o_spi_master_rx,
    output logic o_spi_slave_rx,
    output logic o_spi_slave_select_n,
    output logic o_spi_sck_in,
    output logic o_external_sysclock_in0,
    output logic o_serial_data_in_pin
);
    // ----------------------------------------------------------------
    // Override terms
    // ----------------------------------------------------------------
    logic spi_slave;
    logic spi_master;
    logic external_sysclock_in0_sel;
    logic serial_data_in_pin_sel;
    logic external_sysclock_in0_q;
    logic [PB_W-1:0] b_pullup_override_enable, b_pullup_override_value, b_ddoe, b_port_value_override_enable, b_port_value_override_value, b_input_enable_override_enable;
    logic [PC_W-1:0] c_pullup_override_enable, c_pullup_override_value, c_ddoe, c_ddov, c_port_value_override_enable, c_port_value_override_value, c_input_enable_override_enable;
    logic [PD_W-1:0] d_pullup_override_enable, d_pullup_override_value, d_ddoe, d_port_value_override_enable, d_port_value_override_value, d_input_enable_override_enable;
    logic [PB_W-1:0] b_oe_next, b_out_next, b_pu_next, b_ie_next, pcs_b_next;
    logic [PC_W-1:0] c_oe_next, c_out_next, c_pu_next, c_ie_next, pcs_c_next;
    logic [PD_W-1:0] d_oe_next, d_out_next, d_pu_next, d_ie_next, pcs_d_next;

    assign spi_slave = i_spi_enable_bit && !i_spi_master_select;
    assign spi_master = i_spi_enable_bit && i_spi_master_select;
    assign external_sysclock_in0_sel = (i_clock_module_mode == CMM_EXT) && !i_external_clock_pin_select
        && i_clock_source_select;
    assign serial_data_in_pin_sel = (i_timer2_mode_field == T2M_SSI_SPI);

    // Port B override table
    always_comb begin
        b_pullup_override_enable = '0;
        b_pullup_override_value = '0;
        b_ddoe = '0;
        b_port_value_override_enable = '0;
        b_port_value_override_value = '0;
        // Slave inputs: select, clock, MOSI forced input, pull-up kept
        b_pullup_override_enable[PB_SS] = spi_slave;
        b_pullup_override_enable[PB_SCK] = spi_slave;
        b_pullup_override_enable[PB_MOSI] = spi_slave;
        b_pullup_override_enable[PB_MISO] = spi_master;
        b_pullup_override_value[PB_SS] = i_portb_data[PB_SS] && !i_global_pullup_disable;
        b_pullup_override_value[PB_SCK] = i_portb_data[PB_SCK] && !i_global_pullup_disable;
        b_pullup_override_value[PB_MOSI] = i_portb_data[PB_MOSI] && !i_global_pullup_disable;
        b_pullup_override_value[PB_MISO] = i_portb_data[PB_MISO] && !i_global_pullup_disable;
        b_ddoe[PB_SS] = spi_slave;
        b_ddoe[PB_SCK] = spi_slave;
        b_ddoe[PB_MOSI] = spi_slave;
        b_ddoe[PB_MISO] = spi_master;
        // Output values from SPI and timer 3
        b_port_value_override_enable[PB_SCK] = spi_master;
        b_port_value_override_value[PB_SCK] = i_spi_sck_out;
        b_port_value_override_enable[PB_MOSI] = spi_master;
        b_port_value_override_value[PB_MOSI] = i_spi_master_tx;
        b_port_value_override_enable[PB_MISO] = spi_slave;
        b_port_value_override_value[PB_MISO] = i_spi_slave_tx;
        b_port_value_override_enable[PB_T3OUT] = i_timer3_out_en;
        b_port_value_override_value[PB_T3OUT] = i_timer3_modulator_out;
        // Pin change arms the digital input
        b_input_enable_override_enable = i_pcmask_b & {PB_W{i_pin_change_group_b_enable}};
    end

    // Port C override table
    always_comb begin
        c_pullup_override_enable = '0;
        c_pullup_override_value = '0;
        c_ddoe = '0;
        c_ddov = '0;
        c_port_value_override_enable = '0;
        c_port_value_override_value = '0;
        // Clock out wins over port bits; pull-up off while driving
        c_pullup_override_enable[PC_DIVIDED_CLOCK_OUT] = i_clock_output_fuse;
        c_ddoe[PC_DIVIDED_CLOCK_OUT] = i_clock_output_fuse;
        c_ddov[PC_DIVIDED_CLOCK_OUT] = 1'b1;
        c_port_value_override_enable[PC_DIVIDED_CLOCK_OUT] = i_clock_output_fuse;
        c_port_value_override_value[PC_DIVIDED_CLOCK_OUT] = i_divided_clock_out;
        // Clock input: forced input, no pull-up
        c_pullup_override_enable[PC_ECIN] = external_sysclock_in0_sel;
        c_ddoe[PC_ECIN] = external_sysclock_in0_sel;
        c_input_enable_override_enable = i_pcmask_c & {PC_W{i_pin_change_group_c_enable}};
    end

    // Port D override table, index 0 is pin 5
    always_comb begin
        d_pullup_override_enable = '0;
        d_pullup_override_value = '0;
        d_ddoe = '0;
        d_port_value_override_enable = '0;
        d_port_value_override_value = '0;
        // Pull-up keeps following the data bit, no override needed
        d_ddoe[PD_SERIAL_DATA_IN_PIN-PD_LO] = serial_data_in_pin_sel;
        d_port_value_override_enable[PD_TIMER2_MODULATOR_OUT2-PD_LO] = i_timer2_out2_en;
        d_port_value_override_value[PD_TIMER2_MODULATOR_OUT2-PD_LO] = i_timer2_modulator_out2;
        d_port_value_override_enable[PD_TIMER2_MODULATOR_OUT1-PD_LO] = i_timer2_out1_en;
        d_port_value_override_value[PD_TIMER2_MODULATOR_OUT1-PD_LO] = i_timer2_modulator_out1;
        d_input_enable_override_enable = i_pcmask_d & {PD_W{i_pin_change_group_d_enable}};
    end

    // ----------------------------------------------------------------
    // Per-pin resolution cells
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PB_W; gi++) begin : g_pb
            paf_pin u_pin (
                .i_dir(i_portb_dir[gi]), .i_data(i_portb_data[gi]),
                .i_pud(i_global_pullup_disable), .i_sleep(i_sleep),
                .i_pullup_override_enable(b_pullup_override_enable[gi]), .i_pullup_override_value(b_pullup_override_value[gi]),
                .i_ddoe(b_ddoe[gi]), .i_ddov(1'b0),
                .i_port_value_override_enable(b_port_value_override_enable[gi]), .i_port_value_override_value(b_port_value_override_value[gi]), .i_input_enable_override_enable(b_input_enable_override_enable[gi]),
                .o_oe(b_oe_next[gi]), .o_out(b_out_next[gi]),
                .o_pullup(b_pu_next[gi]), .o_in_en(b_ie_next[gi])
            );
        end
        for (gi = 0; gi < PC_W; gi++) begin : g_pc
            paf_pin u_pin (
                .i_dir(i_portc_dir[gi]), .i_data(i_portc_data[gi]),
                .i_pud(i_global_pullup_disable), .i_sleep(i_sleep),
                .i_pullup_override_enable(c_pullup_override_enable[gi]), .i_pullup_override_value(c_pullup_override_value[gi]),
                .i_ddoe(c_ddoe[gi]), .i_ddov(c_ddov[gi]),
                .i_port_value_override_enable(c_port_value_override_enable[gi]), .i_port_value_override_value(c_port_value_override_value[gi]), .i_input_enable_override_enable(c_input_enable_override_enable[gi]),
                .o_oe(c_oe_next[gi]), .o_out(c_out_next[gi]),
                .o_pullup(c_pu_next[gi]), .o_in_en(c_ie_next[gi])
            );
        end
        for (gi = 0; gi < PD_W; gi++) begin : g_pd
            paf_pin u_pin (
                .i_dir(i_portd_dir[gi]), .i_data(i_portd_data[gi]),
                .i_pud(i_global_pullup_disable), .i_sleep(i_sleep),
                .i_pullup_override_enable(d_pullup_override_enable[gi]), .i_pullup_override_value(d_pullup_override_value[gi]),
                .i_ddoe(d_ddoe[gi]), .i_ddov(1'b0),
                .i_port_value_override_enable(d_port_value_override_enable[gi]), .i_port_value_override_value(d_port_value_override_value[gi]), .i_input_enable_override_enable(d_input_enable_override_enable[gi]),
                .o_oe(d_oe_next[gi]), .o_out(d_out_next[gi]),
                .o_pullup(d_pu_next[gi]), .o_in_en(d_ie_next[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    logic [PB_W-1:0] b_oe_reg, b_out_reg, b_pu_reg, b_ie_reg, pcs_b_reg;
    logic [PC_W-1:0] c_oe_reg, c_out_reg, c_pu_reg, c_ie_reg, pcs_c_reg;
    logic [PD_W-1:0] d_oe_reg, d_out_reg, d_pu_reg, d_ie_reg, pcs_d_reg;
    logic [7:0] per_reg, per_next;

    // Pad drive next values come from the pin cells; pin-change pad inputs go out as seen, some peripheral inputs gated by SPI or clock-input mode
    always_comb begin
        pcs_b_next = i_portb_pad;
        pcs_c_next = i_portc_pad;
        pcs_d_next = i_portd_pad;
        per_next[0] = i_portb_pad[PB_TCLK];
        per_next[1] = i_portb_pad[PB_T3CAP];
        per_next[2] = spi_master && i_portb_pad[PB_MISO];
        per_next[3] = spi_slave && i_portb_pad[PB_MOSI];
        per_next[4] = spi_slave ? i_portb_pad[PB_SS] : 1'b1;
        per_next[5] = i_portb_pad[PB_SCK];
        per_next[6] = external_sysclock_in0_sel && i_portc_pad[PC_ECIN];
        per_next[7] = i_portd_pad[PD_SERIAL_DATA_IN_PIN-PD_LO];
    end

    // Register stage; clock-out pin flops keep running through reset
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            b_oe_reg <= PB_RST;
            b_out_reg <= PB_RST;
            b_pu_reg <= PB_RST;
            b_ie_reg <= PB_RST;
            pcs_b_reg <= PB_RST;
            c_ie_reg <= PC_RST;
            pcs_c_reg <= PC_RST;
            d_oe_reg <= PD_RST;
            d_out_reg <= PD_RST;
            d_pu_reg <= PD_RST;
            d_ie_reg <= PD_RST;
            pcs_d_reg <= PD_RST;
            per_reg <= PER_RST;
        end else begin
            b_oe_reg <= b_oe_next;
            b_out_reg <= b_out_next;
            b_pu_reg <= b_pu_next;
            b_ie_reg <= b_ie_next;
            pcs_b_reg <= pcs_b_next;
            c_ie_reg <= c_ie_next;
            pcs_c_reg <= pcs_c_next;
            d_oe_reg <= d_oe_next;
            d_out_reg <= d_out_next;
            d_pu_reg <= d_pu_next;
            d_ie_reg <= d_ie_next;
            pcs_d_reg <= pcs_d_next;
            per_reg <= per_next;
        end
    end

    // Port C drive has no reset so the fuse-selected clock survives reset
    always_ff @(posedge i_mclk) begin
        c_oe_reg <= c_oe_next;
        c_out_reg <= c_out_next;
        c_pu_reg <= c_pu_next;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_portb_oe = b_oe_reg;
    assign o_portb_out = b_out_reg;
    assign o_portb_pullup = b_pu_reg;
    assign o_portb_in_en = b_ie_reg;
    assign o_portc_oe = c_oe_reg;
    assign o_portc_out = c_out_reg;
    assign o_portc_pullup = c_pu_reg;
    assign o_portc_in_en = c_ie_reg;
    assign o_portd_oe = d_oe_reg;
    assign o_portd_out = d_out_reg;
    assign o_portd_pullup = d_pu_reg;
    assign o_portd_in_en = d_ie_reg;
    assign o_pin_change_source_b = pcs_b_reg;
    assign o_pin_change_source_c = pcs_c_reg;
    assign o_pin_change_source_d = pcs_d_reg;
    assign o_timer_ext_clock_in_b = per_reg[0];
    assign o_timer3_capture_in = per_reg[1];
    assign o_spi_master_rx = per_reg[2];
    assign o_spi_slave_rx = per_reg[3];
    assign o_spi_slave_select_n = per_reg[4];
    assign o_spi_sck_in = per_reg[5];
    assign o_external_sysclock_in0 = per_reg[6];
    assign o_serial_data_in_pin = per_reg[7];
    assign o_portc_bit0_data_reads_zero = per_reg[6] || (external_sysclock_in0_q);

    // Clock-input select registered for readback masking
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            external_sysclock_in0_q <= 1'b0;
        end else begin
            external_sysclock_in0_q <= external_sysclock_in0_sel;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_divided_clock_out_force: assert property (@(posedge i_mclk) i_clock_output_fuse |=>
        (o_portc_oe[PC_DIVIDED_CLOCK_OUT] && o_portc_out[PC_DIVIDED_CLOCK_OUT] == $past(i_divided_clock_out)))
        else $error("clock out pin not forced");
    chk_t3_drive: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        i_timer3_out_en |=> o_portb_out[PB_T3OUT] == $past(i_timer3_modulator_out))
        else $error("timer3 value not on pin");
    chk_tclk_route: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        1'b1 |=> o_timer_ext_clock_in_b == $past(i_portb_pad[PB_TCLK]))
        else $error("timer clock input not routed");
    chk_miso_slave: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        spi_slave |=> o_portb_out[PB_MISO] == $past(i_spi_slave_tx))
        else $error("slave data not on miso");
    chk_mosi_in: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        spi_slave |=> !o_portb_oe[PB_MOSI])
        else $error("mosi not forced input as slave");
    chk_serial_data_in_pin_input: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        serial_data_in_pin_sel |=> !o_portd_oe[PD_SERIAL_DATA_IN_PIN-PD_LO])
        else $error("serial in pin not forced input");
    chk_ecin_input: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        external_sysclock_in0_sel |=> !o_portc_oe[PC_ECIN] && o_portc_bit0_data_reads_zero)
        else $error("clock input pin not isolated");
    chk_pc_arm: assert property (@(posedge i_mclk) disable iff (!i_resetn)
        (i_pcmask_b[0] && i_pin_change_group_b_enable) |=> o_portb_in_en[0])
        else $error("armed pin input disabled");
endmodule

// ---- dv/paf_pads.sv ----
// Far-side pad model: resolves each pin from device drive, outside drivers and pull-ups
`timescale 1ns/10ps
module paf_pads #(
    parameter int W = 8
) (
    // Clock
    input wire logic i_mclk,
    // Device pad drive
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_pullup,
    // Outside drivers
    input wire logic [W-1:0] i_ext_en,
    input wire logic [W-1:0] i_ext_val,
    input wire logic i_ext_ss_low,
    // Resolved pad levels
    output logic [W-1:0] o_pad
);
    logic [W-1:0] float_reg = '0;
    // Floating pins toggle every cycle so a stale level never passes for a real one
    always @(posedge i_mclk) begin
        float_reg <= ~float_reg;
    end
    // Device drive wins, then outside driver, then pull-up, else floating
    always_comb begin
        for (int n = 0; n < W; n++) begin
            if (i_oe[n]) o_pad[n] = i_out[n];
            else if (i_ext_en[n]) o_pad[n] = i_ext_val[n];
            else if (i_pullup[n]) o_pad[n] = 1'b1;
            else o_pad[n] = float_reg[n];
        end
        // Outside SPI master selects the device by pulling the top pin low
        if (i_ext_ss_low && W == 8 && !i_oe[W-1]) o_pad[W-1] = 1'b0;
    end
endmodule

// ---- dv/tb_port_alternate_function_override.sv ----
// Self-checking bench: random pin and peripheral stimulus against a reference model
`timescale 1ns/10ps
module tb_port_alternate_function_override;
    import paf_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus, observed outputs and expectations
    // ----------------------------------------------------------------
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic global_pullup_disable, slp, fuse, dclk, spi_enable_bit, spi_master_select, sck, mtx, stx, t3e, t3o, pdclk;
    logic t2e1, timer2_modulator_out1, t2e2, timer2_modulator_out2, ecs, clock_source_select, gb, gc, gd, ssl;
    logic [7:0] bd, bdir, bm, bxe, bxv, boe, bout, bpu, bie, bpad, pcb;
    logic [7:0] e_boe, e_bout, e_bpu, e_bie;
    logic [2:0] cd, cdir, cm, cxe, cxv, coe, cout, cpu, cie, cpad, pcc;
    logic [2:0] dd, ddir, dm, dxe, dxv, doe, dout, dpu, die, dpad, pcd;
    logic [2:0] e_coe, e_cout, e_cpu, e_cie, e_doe, e_dout, e_dpu, e_die;
    logic [3:0] t2m;
    logic [1:0] clock_module_mode;
    logic c0z, tck, tcap, mrx, srx, ssn, scki, ecin, serial_data_in_pin, sl, ms, c0;
    logic [8:0] e_per;
    logic [13:0] e_pc;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    integer seed = 32'hA8479798;

    // Clock at 40 MHz
    always #12.5 i_mclk = ~i_mclk;

    paf_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_global_pullup_disable(global_pullup_disable),
        .i_sleep(slp), .i_clock_output_fuse(fuse), .i_divided_clock_out(dclk),
        .i_portb_data(bd), .i_portb_dir(bdir), .i_portc_data(cd), .i_portc_dir(cdir),
        .i_portd_data(dd), .i_portd_dir(ddir), .i_portb_pad(bpad), .i_portc_pad(cpad),
        .i_portd_pad(dpad), .i_pcmask_b(bm), .i_pcmask_c(cm), .i_pcmask_d(dm),
        .i_pin_change_group_b_enable(gb), .i_pin_change_group_c_enable(gc),
        .i_pin_change_group_d_enable(gd), .i_spi_enable_bit(spi_enable_bit), .i_spi_master_select(spi_master_select),
        .i_spi_sck_out(sck), .i_spi_master_tx(mtx), .i_spi_slave_tx(stx),
        .i_timer3_out_en(t3e), .i_timer3_modulator_out(t3o), .i_timer2_mode_field(t2m),
        .i_timer2_out1_en(t2e1), .i_timer2_modulator_out1(timer2_modulator_out1), .i_timer2_out2_en(t2e2),
        .i_timer2_modulator_out2(timer2_modulator_out2), .i_clock_module_mode(clock_module_mode),
        .i_external_clock_pin_select(ecs), .i_clock_source_select(clock_source_select),
        .o_portb_oe(boe), .o_portb_out(bout), .o_portb_pullup(bpu), .o_portb_in_en(bie),
        .o_portc_oe(coe), .o_portc_out(cout), .o_portc_pullup(cpu), .o_portc_in_en(cie),
        .o_portd_oe(doe), .o_portd_out(dout), .o_portd_pullup(dpu), .o_portd_in_en(die),
        .o_portc_bit0_data_reads_zero(c0z), .o_pin_change_source_b(pcb), .o_pin_change_source_c(pcc),
        .o_pin_change_source_d(pcd), .o_timer_ext_clock_in_b(tck), .o_timer3_capture_in(tcap),
        .o_spi_master_rx(mrx), .o_spi_slave_rx(srx), .o_spi_slave_select_n(ssn),
        .o_spi_sck_in(scki), .o_external_sysclock_in0(ecin), .o_serial_data_in_pin(serial_data_in_pin));
    paf_pads #(.W(8)) pads_b (.i_mclk(i_mclk), .i_oe(boe), .i_out(bout), .i_pullup(bpu),
        .i_ext_en(bxe), .i_ext_val(bxv), .i_ext_ss_low(ssl), .o_pad(bpad));
    paf_pads #(.W(3)) pads_c (.i_mclk(i_mclk), .i_oe(coe), .i_out(cout), .i_pullup(cpu),
        .i_ext_en(cxe), .i_ext_val(cxv), .i_ext_ss_low(1'b0), .o_pad(cpad));
    paf_pads #(.W(3)) pads_d (.i_mclk(i_mclk), .i_oe(doe), .i_out(dout), .i_pullup(dpu),
        .i_ext_en(dxe), .i_ext_val(dxv), .i_ext_ss_low(1'b0), .o_pad(dpad));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Masked compare; only driven pins count for output values
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g,
                       input logic [31:0] m);
        n_checks++;
        if ((g & m) !== (e & m)) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask
    // New random inputs on every level input; f keeps the clock fuse set
    task automatic rand_in(input logic f);
        logic [127:0] r;
        r = {$random(seed), $random(seed), $random(seed), $random(seed)};
        {bd, bdir, bm, bxe, bxv, cd, cdir, cm, cxe, cxv, dd, ddir, dm, dxe, dxv} <= r[69:0];
        {t2m, clock_module_mode, global_pullup_disable, slp} <= r[77:70];
        fuse <= r[78] | f;
        {dclk, spi_enable_bit, spi_master_select, sck, mtx, stx, t3e, t3o} <= r[86:79];
        {t2e1, timer2_modulator_out1, t2e2, timer2_modulator_out2, ecs, clock_source_select, gb, gc, gd, ssl} <= r[96:87];
    endtask
    // Reference model of the settled inputs; checked one edge later
    task automatic model();
        sl = spi_enable_bit & ~spi_master_select;
        ms = spi_enable_bit & spi_master_select;
        c0 = (clock_module_mode == CMM_EXT) & ~ecs & clock_source_select;
        {e_boe, e_bout, e_bpu} = {bdir, bd, ~bdir & bd & {8{~global_pullup_disable}}};
        {e_coe, e_cout, e_cpu} = {cdir, cd, ~cdir & cd & {3{~global_pullup_disable}}};
        {e_doe, e_dout, e_dpu} = {ddir, dd, ~ddir & dd & {3{~global_pullup_disable}}};
        e_bie = (bm & {8{gb}}) | {8{~slp}};
        e_cie = (cm & {3{gc}}) | {3{~slp}};
        e_die = (dm & {3{gd}}) | {3{~slp}};
        if (sl) {e_boe[7], e_boe[5], e_boe[3], e_bout[4]} = {3'h0, stx};
        if (sl) {e_bpu[7], e_bpu[5], e_bpu[3]} = {bd[7], bd[5], bd[3]} & {3{~global_pullup_disable}};
        if (ms) {e_boe[4], e_bpu[4], e_bout[5], e_bout[3]} = {1'b0, bd[4] & ~global_pullup_disable, sck, mtx};
        if (t3e) e_bout[1] = t3o;
        if (fuse) {e_coe[1], e_cout[1], e_cpu[1]} = {1'b1, dclk, 1'b0};
        if (c0) {e_coe[0], e_cpu[0]} = 2'h0;
        if (t2m == T2M_SSI_SPI) {e_doe[2], e_dpu[2]} = {1'b0, dd[2] & ~global_pullup_disable};
        if (t2e2) e_dout[1] = timer2_modulator_out2;
        if (t2e1) e_dout[0] = timer2_modulator_out1;
        e_pc = {bpad, cpad, dpad};
        e_per = {c0, bpad[2], bpad[0], ms & bpad[4], sl & bpad[3], ~sl | bpad[7], bpad[5],
                 c0 & cpad[0], dpad[2]};
    endtask
    task automatic check();
        cmp("b_oe", e_boe, boe, '1);
        cmp("b_out", e_bout, bout, e_boe);
        cmp("b_pull", e_bpu, bpu, '1);
        cmp("b_in_en", e_bie, bie, '1);
        cmp("c_oe", e_coe, coe, '1);
        cmp("c_out", e_cout, cout, e_coe);
        cmp("c_pull", e_cpu, cpu, '1);
        cmp("c_in_en", e_cie, cie, '1);
        cmp("d_oe", e_doe, doe, '1);
        cmp("d_out", e_dout, dout, e_doe);
        cmp("d_pull", e_dpu, dpu, '1);
        cmp("d_in_en", e_die, die, '1);
        cmp("pc_src", e_pc, {pcb, pcc, pcd}, '1);
        cmp("per_b", e_per[7:2], {tck, tcap, mrx, srx, ssn, scki}, '1);
        cmp("per_cd", {e_per[8], e_per[1:0]}, {c0z, ecin, serial_data_in_pin}, '1);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Sequence and hang guard
    // ----------------------------------------------------------------
    // Ceiling well above the 621 cycles the run needs
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        rand_in(1'b1);
        // Clock fuse set through reset: divided clock must keep reaching the pin
        for (int i = 0; i < 20; i++) begin
            @(posedge i_mclk);
            rand_in(1'b1);
            @(negedge i_mclk);
            if (i > 0) cmp("c1_reset", {1'b1, pdclk}, {coe[1], cout[1]}, '1);
            cmp("reset_vals", {8'h00, 1'b1}, {boe, ssn}, '1);
            pdclk = dclk;
        end
        $display("test reset done");
        @(posedge i_mclk);
        i_resetn <= 1'b1;
        rand_in(1'b0);
        for (int k = 0; k < 600; k++) begin
            @(negedge i_mclk);
            if (k > 0) check();
            model();
            @(posedge i_mclk);
            rand_in(1'b0);
        end
        $display("test random done");
        print_verdict();
    end
endmodule
